/* design/capcmp_pkg.sv */
package capcmp_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [4:0] RUN_OFF   = 5'h00; // Run control: bit0 run, bit1 prescaler run
   localparam logic [4:0] MODE_OFF  = 5'h04; // timer_mode_reg
   localparam logic [4:0] FFCR_OFF  = 5'h08; // flipflop_control_reg
   localparam logic [4:0] CMP0_OFF  = 5'h0c; // compare_reg_0
   localparam logic [4:0] CMP1_OFF  = 5'h10; // compare_reg_1
   localparam logic [4:0] CAP0_OFF  = 5'h14; // capture_reg_0, read only
   localparam logic [4:0] CAP1_OFF  = 5'h18; // capture_reg_1, read only
   localparam logic [4:0] CNT_OFF   = 5'h1c; // up_counter, read only

   // Run register fields
   localparam int RUN_EN_BIT  = 0;
   localparam int RUN_PRE_BIT = 1;

   // Mode register fields
   localparam int MODE_CLK_LSB  = 0; // Clock source select, 2 bits
   localparam int MODE_CLR_BIT  = 2; // Clear counter on compare-1 match
   localparam int MODE_CPM_LSB  = 3; // capture_trigger_select, 2 bits
   localparam int MODE_SWCAP_BIT = 5; // Write 1: software capture into capture_reg_0

   // Clock source codes
   localparam logic [1:0] CLK_EVENT = 2'h0; // capture_input_0 rising edges
   localparam logic [1:0] CLK_TAP1  = 2'h1;
   localparam logic [1:0] CLK_TAP2  = 2'h2;
   localparam logic [1:0] CLK_TAP3  = 2'h3;

   // Capture trigger codes
   localparam logic [1:0] CPM_OFF    = 2'h0;
   localparam logic [1:0] CPM_IN0    = 2'h1; // cap0 rise in0, cap1 fall in0
   localparam logic [1:0] CPM_TWO    = 2'h2; // cap0 rise in0, cap1 rise in1
   localparam logic [1:0] CPM_GATE   = 2'h3; // cap0 rise gate, cap1 fall gate

   // Flip-flop control fields
   localparam int FF_E0_BIT   = 0; // compare0_toggle_enable
   localparam int FF_E1_BIT   = 1; // compare1_toggle_enable
   localparam int FF_C0_BIT   = 2; // capture toggle enable
   localparam int FF_CTL_LSB  = 4; // 2-bit write command: 01 set, 10 clear, 11 invert

   // Reset values
   localparam logic [7:0]  MODE_RST = 8'h00;
   localparam logic [3:0]  FFCR_RST = 4'h0;
   localparam logic [15:0] CMP_RST  = 16'h0000;

   // Prescaler tap positions as power-of-two divisors
   localparam int TAP1_LOG = 2;
   localparam int TAP2_LOG = 4;
   localparam int TAP3_LOG = 6;

endpackage : capcmp_pkg

/* design/capture_compare_timer16.sv */
// Contract
// - Trigger select 11 picks gating flip-flop
// - Gate rise to cap0, next fall cap1
// - Event counting clocks counter from input 0
// - Timing mode: counter free-runs on prescaler tap
// - Input0 rise to cap0, next fall cap1
// - Two-input mode: input0 rise loads cap0
// - Two-input mode: input1 rise loads cap1
// - Capture toggle enable toggles on cap0 load
// - Compare-1 enable toggles on compare-1 match
// - Compare-1 match raises interrupt
// - Clearing match enables stops match toggling only
// - Each match enable toggles only on its own compare match
// - Software capture also toggles output flip-flop
`timescale 1ns/1ps
`default_nettype none

module capture_compare_timer16 #(
   parameter int CNT_W = 16,              // Counter width
   parameter int PRE_W = 8                // Prescaler width
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone slave
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [4:0]       adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [31:0]      dat_i,
   output logic      [31:0]      dat_o,
   output logic                  ack_o,
   // Pins and companion timer
   input  wire logic             capture_input_0_i,
   input  wire logic             capture_input_1_i,
   input  wire logic             gating_flipflop_i,
   output logic                  pulse_output_o,
   output logic                  compare1_match_irq_o,
   output logic                  compare0_match_o
);

   // Refuse sizes the logic cannot serve: the bus map packs the counter
   // into the low half word, and the slowest tap must exist in the
   // prescaler, or that clock source would never tick
   initial begin
      if (CNT_W != 16 || PRE_W <= capcmp_pkg::TAP3_LOG) begin
         $error("capture_compare_timer16: unsupported parameters");
      end
   end

   // Whole module state
   // Kept in one packed word so that reset, next-state and register
   // stay in step; every output is a field of it, hence a flip-flop
   typedef struct packed {
      logic [31:0]      rdat;    // Read data
      logic             ack;     // Bus acknowledge
      logic [1:0]       run;     // Run and prescaler run
      logic [7:0]       mode;    // Mode register
      logic [3:0]       ffcr;    // Flip-flop control enables
      logic [CNT_W-1:0] cmp0;    // compare_reg_0
      logic [CNT_W-1:0] cmp1;    // compare_reg_1
      logic [CNT_W-1:0] cap0;    // capture_reg_0
      logic [CNT_W-1:0] cap1;    // capture_reg_1
      logic [CNT_W-1:0] cnt;     // up_counter
      logic [PRE_W-1:0] pre;     // Prescaler
      logic             in0_d;   // Previous capture_input_0
      logic             in1_d;   // Previous capture_input_1
      logic             gate_d;  // Previous gating flip-flop
      logic             ff;      // output_flipflop
      logic             irq1;    // Compare-1 match pulse
      logic             irq0;    // Compare-0 match pulse
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // Prescaler tap selection, a tick when the chosen bit falls
   // The falling bit marks one full period of that divided clock, so
   // a tap of log2 n gives exactly one tick every n cycles
   function automatic logic tap_tick(input logic [PRE_W-1:0] p,
                                     input logic [PRE_W-1:0] pn,
                                     input logic [1:0] sel);
      int b;
      b = (sel == capcmp_pkg::CLK_TAP1) ? capcmp_pkg::TAP1_LOG :
          (sel == capcmp_pkg::CLK_TAP2) ? capcmp_pkg::TAP2_LOG : capcmp_pkg::TAP3_LOG;
      return p[b-1] && !pn[b-1];
   endfunction : tap_tick

   // Byte-lane write merge
   // Lanes with a clear select keep the old byte, so a partial write
   // never disturbs the other fields of the same word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Next state
   always_comb begin
      // Bus request decode
      logic             req;
      logic             wr;
      logic [31:0]      wv;
      // Counter advance
      logic             tick;
      // Pin edges against the previous sample
      logic             in0_rise;
      logic             in0_fall;
      logic             in1_rise;
      logic             g_rise;
      logic             g_fall;
      // Capture and toggle causes
      logic             swcap;
      logic             c0_trig;
      logic             c1_trig;
      logic             m0;
      logic             m1;
      logic             tog;
      // Field copies
      logic [1:0]       cpm;
      logic [1:0]       csel;
      logic [PRE_W-1:0] pn;
      // Every local starts from a known value so no path leaves a latch
      tick     = 1'b0;
      in0_rise = 1'b0;
      in0_fall = 1'b0;
      in1_rise = 1'b0;
      g_rise   = 1'b0;
      g_fall   = 1'b0;
      c0_trig  = 1'b0;
      c1_trig  = 1'b0;
      m0       = 1'b0;
      m1       = 1'b0;
      tog      = 1'b0;
      pn       = '0;
      // Default: every field holds
      st_nxt   = st_r;
      req      = cyc_i && stb_i && !st_r.ack;
      wr       = req && we_i;
      wv       = 32'h0000_0000;
      swcap    = 1'b0;
      cpm      = st_r.mode[capcmp_pkg::MODE_CPM_LSB +: 2];
      csel     = st_r.mode[capcmp_pkg::MODE_CLK_LSB +: 2];
      // Edges are judged against last cycle's sample; the samples start
      // low, matching the idle level of the pins, so reset gives no edge
      in0_rise = capture_input_0_i && !st_r.in0_d;
      in0_fall = !capture_input_0_i && st_r.in0_d;
      in1_rise = capture_input_1_i && !st_r.in1_d;
      g_rise   = gating_flipflop_i && !st_r.gate_d;
      g_fall   = !gating_flipflop_i && st_r.gate_d;
      // Remember this cycle's pin levels for the next edge test
      st_nxt.in0_d  = capture_input_0_i;
      st_nxt.in1_d  = capture_input_1_i;
      st_nxt.gate_d = gating_flipflop_i;
      // Prescaler runs only while enabled
      pn = st_r.run[capcmp_pkg::RUN_PRE_BIT] ? st_r.pre + 1'b1 : '0;
      st_nxt.pre = pn;
      // Counter clock source
      // Event mode counts rises of input 0; the other codes pick a tap
      if (csel == capcmp_pkg::CLK_EVENT) begin
         tick = in0_rise;
      end else begin
         tick = tap_tick(st_r.pre, pn, csel);
      end
      // A stopped counter never ticks, so no match can fire either
      tick = tick && st_r.run[capcmp_pkg::RUN_EN_BIT];
      // Matches are judged on the current count when it advances
      m0 = tick && (st_r.cnt == st_r.cmp0);
      m1 = tick && (st_r.cnt == st_r.cmp1);
      // Counter update; stop clears it so each run starts from zero
      if (!st_r.run[capcmp_pkg::RUN_EN_BIT]) begin
         st_nxt.cnt = '0;
      // Optional interval mode: compare 1 ends the period
      end else if (m1 && st_r.mode[capcmp_pkg::MODE_CLR_BIT]) begin
         st_nxt.cnt = '0;
      // Plain count up, wrapping at the full width
      end else if (tick) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
      // Bus writes
      // A write lands on the edge that takes the request; ack follows
      if (wr) begin
         unique case (adr_i)
            // Run and prescaler run bits
            capcmp_pkg::RUN_OFF: begin
               wv = merge({30'h0, st_r.run}, dat_i, sel_i);
               st_nxt.run = wv[1:0];
            end
            // Mode; the software capture bit acts once and reads back 0
            capcmp_pkg::MODE_OFF: begin
               wv = merge({24'h0, st_r.mode}, dat_i, sel_i);
               st_nxt.mode = {2'h0, 1'b0, wv[4:0]};
               swcap = sel_i[0] && wv[capcmp_pkg::MODE_SWCAP_BIT];
            end
            // Toggle enables, plus a one-shot set, clear or invert command
            capcmp_pkg::FFCR_OFF: begin
               wv = merge({28'h0, st_r.ffcr}, dat_i, sel_i);
               st_nxt.ffcr = {1'b0, wv[2:0]};
               if (sel_i[0]) begin
                  unique case (dat_i[capcmp_pkg::FF_CTL_LSB +: 2])
                     2'h1:    st_nxt.ff = 1'b1;
                     2'h2:    st_nxt.ff = 1'b0;
                     2'h3:    st_nxt.ff = !st_r.ff;
                     default: st_nxt.ff = st_r.ff;
                  endcase
               end
            end
            // Compare values, taken whole with no shadow buffer
            capcmp_pkg::CMP0_OFF: begin
               wv = merge({16'h0, st_r.cmp0}, dat_i, sel_i);
               st_nxt.cmp0 = wv[CNT_W-1:0];
            end
            capcmp_pkg::CMP1_OFF: begin
               wv = merge({16'h0, st_r.cmp1}, dat_i, sel_i);
               st_nxt.cmp1 = wv[CNT_W-1:0];
            end
            // Read-only and unmapped addresses ignore writes
            default: begin
            end
         endcase
      end
      // Capture triggers per selected source
      // Software capture is honoured in every select, even with none
      c0_trig = swcap;
      c1_trig = 1'b0;
      unique case (cpm)
         // Pulse width: rise then fall of input 0
         capcmp_pkg::CPM_IN0: begin
            c0_trig = c0_trig || in0_rise;
            c1_trig = in0_fall;
         end
         // Time difference: rise of input 0, then rise of input 1
         capcmp_pkg::CPM_TWO: begin
            c0_trig = c0_trig || in0_rise;
            c1_trig = in1_rise;
         end
         // Frequency: the companion timer's gate opens and closes
         capcmp_pkg::CPM_GATE: begin
            c0_trig = c0_trig || g_rise;
            c1_trig = g_fall;
         end
         default: begin
         end
      endcase
      // Registers change only on their own trigger
      // The value latched is the count of the cycle the edge is seen
      if (c0_trig) begin
         st_nxt.cap0 = st_r.cnt;
      end
      if (c1_trig) begin
         st_nxt.cap1 = st_r.cnt;
      end
      // Toggle triggers; one toggle per cycle even if several coincide
      // The toggle applies on top of a command written in the same
      // cycle, so software's level wins first and the event follows
      tog = (m0 && st_r.ffcr[capcmp_pkg::FF_E0_BIT])
         || (m1 && st_r.ffcr[capcmp_pkg::FF_E1_BIT])
         || (c0_trig && st_r.ffcr[capcmp_pkg::FF_C0_BIT]);
      if (tog) begin
         st_nxt.ff = !st_nxt.ff;
      end
      // Match pulses last one cycle, one per match
      st_nxt.irq1 = m1;
      st_nxt.irq0 = m0;
      // Bus answer, one wait-free cycle then ack drops
      st_nxt.ack  = req;
      // Read data stays zero outside the acknowledge cycle
      st_nxt.rdat = 32'h0000_0000;
      // Read mux samples the registers on the edge that takes the read
      if (req && !we_i) begin
         unique case (adr_i)
            capcmp_pkg::RUN_OFF:  st_nxt.rdat = {30'h0, st_r.run};
            capcmp_pkg::MODE_OFF: st_nxt.rdat = {24'h0, st_r.mode};
            capcmp_pkg::FFCR_OFF: st_nxt.rdat = {27'h0, st_r.ff, st_r.ffcr};
            capcmp_pkg::CMP0_OFF: st_nxt.rdat = {16'h0, st_r.cmp0};
            capcmp_pkg::CMP1_OFF: st_nxt.rdat = {16'h0, st_r.cmp1};
            capcmp_pkg::CAP0_OFF: st_nxt.rdat = {16'h0, st_r.cap0};
            capcmp_pkg::CAP1_OFF: st_nxt.rdat = {16'h0, st_r.cap1};
            capcmp_pkg::CNT_OFF:  st_nxt.rdat = {16'h0, st_r.cnt};
            default:              st_nxt.rdat = 32'h0000_0000;
         endcase
      end
   end

   // State register
   // Synchronous reset; the compare and control fields take their own
   // reset constants so they can differ from zero later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r      <= '0;
         st_r.mode <= capcmp_pkg::MODE_RST;
         st_r.ffcr <= capcmp_pkg::FFCR_RST;
         st_r.cmp0 <= capcmp_pkg::CMP_RST;
         st_r.cmp1 <= capcmp_pkg::CMP_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state
   // No logic sits between these flip-flops and the pins
   assign dat_o                = st_r.rdat;
   assign ack_o                = st_r.ack;
   assign pulse_output_o       = st_r.ff;
   assign compare1_match_irq_o = st_r.irq1;
   assign compare0_match_o     = st_r.irq0;

endmodule : capture_compare_timer16

`default_nettype wire

/* verif/capcmp_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the capture and compare timer
module capcmp_chk #(
   parameter int CNT_W = 16, // Counter width
   parameter int PRE_W = 8   // Prescaler width
) (
   // Clock, reset and bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [4:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // Pins
   input wire logic        capture_input_0_i,
   input wire logic        capture_input_1_i,
   input wire logic        gating_flipflop_i,
   input wire logic        pulse_output_o,
   input wire logic        compare1_match_irq_o,
   input wire logic        compare0_match_o
);
   logic [2:0] quiet_r; // Edges since a bus cycle or pin change
   logic       e1_r;    // Shadow of compare-1 toggle enable
   // Track causes other than matches that may move the flip-flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         quiet_r <= 3'h0;
         e1_r    <= 1'b0;
      end else begin
         if (cyc_i || $changed({capture_input_0_i, capture_input_1_i, gating_flipflop_i}))
            quiet_r <= 3'h0;
         else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
         if (ack_o && we_i && adr_i == capcmp_pkg::FFCR_OFF && sel_i[0])
            e1_r <= dat_i[capcmp_pkg::FF_E1_BIT];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus request, single ack, and a match with no other cause around
   sequence req_s; cyc_i && stb_i && !ack_o; endsequence
   sequence ack_s; ack_o ##1 !ack_o; endsequence
   sequence calm_s; quiet_r >= 3'h4 && !compare0_match_o; endsequence
   ack_follows_a:
      assert property (req_s |=> ack_s) else $error("no single ack after request");
   ack_cause_a:
      assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
   dat_idle_a:
      assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
   irq_single_a:
      assert property (compare1_match_irq_o |=> !compare1_match_irq_o)
      else $error("compare-1 irq longer than one cycle");
   cmp0_single_a:
      assert property (compare0_match_o |=> !compare0_match_o)
      else $error("compare-0 pulse longer than one cycle");
   toggle_cause_a:
      assert property ($changed(pulse_output_o) |->
         compare0_match_o || compare1_match_irq_o || quiet_r < 3'h4)
      else $error("output flip-flop moved without cause");
   match_toggle_a:
      assert property ((compare1_match_irq_o && e1_r) ##0 calm_s |-> $changed(pulse_output_o))
      else $error("compare-1 match did not toggle");
   match_hold_a:
      assert property ((compare1_match_irq_o && !e1_r) ##0 calm_s |-> $stable(pulse_output_o))
      else $error("disabled match toggled output");
endmodule : capcmp_chk
bind capture_compare_timer16 capcmp_chk #(.CNT_W(CNT_W), .PRE_W(PRE_W)) chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .capture_input_0_i(capture_input_0_i), .capture_input_1_i(capture_input_1_i),
   .gating_flipflop_i(gating_flipflop_i), .pulse_output_o(pulse_output_o),
   .compare1_match_irq_o(compare1_match_irq_o), .compare0_match_o(compare0_match_o));
`default_nettype wire

/* verif/pulse_source.sv */
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the external pulse pins and the companion byte timer
module pulse_source (
   // Clock
   input  wire logic clk_i,
   // Pins towards the timer
   output logic      capture_input_0_o,
   output logic      capture_input_1_o,
   output logic      gating_flipflop_o
);
   // All pins idle low until commanded
   initial begin
      capture_input_0_o = 1'b0;
      capture_input_1_o = 1'b0;
      gating_flipflop_o = 1'b0;
   end
   // Set the three pins just after an edge, then hold them for n edges
   task automatic drive(input logic a, input logic b, input logic g, input int n);
      capture_input_0_o <= a;
      capture_input_1_o <= b;
      gating_flipflop_o <= g;
      repeat (n) @(posedge clk_i);
   endtask : drive
   // Train of k pulses on input 0, hi edges high and hi edges low
   task automatic burst(input int k, input int hi);
      repeat (k) begin
         drive(1'b1, capture_input_1_o, gating_flipflop_o, hi);
         drive(1'b0, capture_input_1_o, gating_flipflop_o, hi);
      end
   endtask : burst
endmodule : pulse_source
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {logic [31:0] v; logic [31:0] m;} note_t; // Expected word and mask
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [4:0]  adr_i = 5'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o, rd_v, c0;
   logic        ack_o, pout, irq, cm0, in0, in1, gate;
   note_t       q[$];                                  // Expected reads in issue order
   int          fails = 0, checked = 0, irq_n = 0, seed = 32'h60df, h, base;
   int          cm0_n = 0, base0;                      // Compare-0 pulse count
   logic [31:0] ffc[3] = '{32'h23, 32'h12, 32'h10};    // Toggle settings under test
   logic        ffe[3] = '{1'b0, 1'b0, 1'b1};          // Flip-flop level after both matches
   always #2.5 clk_i = ~clk_i;
   capture_compare_timer16 dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .capture_input_0_i(in0), .capture_input_1_i(in1), .gating_flipflop_i(gate),
      .pulse_output_o(pout), .compare1_match_irq_o(irq), .compare0_match_o(cm0));
   pulse_source src (.clk_i(clk_i), .capture_input_0_o(in0), .capture_input_1_o(in1),
      .gating_flipflop_o(gate));
   // Compare a read word under its mask
   task automatic chk_rd(input logic [31:0] got, input note_t n);
      checked++;
      if ((got & n.m) !== (n.v & n.m)) begin
         fails++;
         $display("BAD %0t read %h expected %h", $time, got, n.v);
      end
   endtask : chk_rd
   // Compare a derived number
   task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t value %0d expected %0d", $time, got, exp);
      end
   endtask : chk_num
   // Watch outputs: count compare-1 and compare-0 pulses, check every read answer
   always @(posedge clk_i) begin
      if (irq === 1'b1) irq_n++;
      if (cm0 === 1'b1) cm0_n++;
      if (ack_o === 1'b1 && we_i === 1'b0 && q.size() > 0) chk_rd(dat_o, q.pop_front());
   end
   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      rd_v = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      if (n >= 40) fails++;
      @(posedge clk_i);
   endtask : wb
   // Read with an expectation noted first
   task automatic rd(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m);
      q.push_back('{v, m});
      wb(1'b0, a, 32'h0);
   endtask : rd
   // Mode word from clock source and capture select
   function automatic logic [31:0] md(input logic [1:0] c, input logic [1:0] p);
      return (32'(c) << capcmp_pkg::MODE_CLK_LSB) | (32'(p) << capcmp_pkg::MODE_CPM_LSB);
   endfunction : md
   // Verdict and end of run
   task automatic test_done();
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      test_done();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Reset values, read-only capture, compare read-back
      rd(capcmp_pkg::MODE_OFF, 32'(capcmp_pkg::MODE_RST), 32'h3f);
      rd(capcmp_pkg::FFCR_OFF, 32'(capcmp_pkg::FFCR_RST), 32'h17);
      h = $random(seed);
      wb(1'b1, capcmp_pkg::CMP0_OFF, {16'h0, h[15:0]});
      rd(capcmp_pkg::CMP0_OFF, {16'h0, h[15:0]}, 32'hffff);
      wb(1'b1, capcmp_pkg::CAP0_OFF, 32'hffff);
      rd(capcmp_pkg::CAP0_OFF, 32'h0, 32'hffff);
      // Event counting with captures on the gate edges
      wb(1'b1, capcmp_pkg::MODE_OFF, md(capcmp_pkg::CLK_EVENT, capcmp_pkg::CPM_GATE));
      wb(1'b1, capcmp_pkg::RUN_OFF, 32'h1);
      src.burst(5, 2);
      src.drive(1'b0, 1'b0, 1'b1, 6);
      src.burst(3, 2);
      src.drive(1'b0, 1'b0, 1'b0, 6);
      src.burst(2, 2);
      rd(capcmp_pkg::CNT_OFF, 32'd10, 32'hffff);
      rd(capcmp_pkg::CAP0_OFF, 32'd5, 32'hffff);
      rd(capcmp_pkg::CAP1_OFF, 32'd8, 32'hffff);
      src.burst(4, 2);
      rd(capcmp_pkg::CAP0_OFF, 32'd5, 32'hffff);
      // Prescaled timer, pulse width on input 0, capture toggle on
      h = 4 * (4 + ($unsigned($random(seed)) % 8));
      wb(1'b1, capcmp_pkg::RUN_OFF, 32'h0);
      wb(1'b1, capcmp_pkg::FFCR_OFF, 32'h24);
      wb(1'b1, capcmp_pkg::MODE_OFF, md(capcmp_pkg::CLK_TAP1, capcmp_pkg::CPM_IN0));
      wb(1'b1, capcmp_pkg::RUN_OFF, 32'h3);
      src.drive(1'b1, 1'b0, 1'b0, h);
      src.drive(1'b0, 1'b0, 1'b0, 4);
      rd(capcmp_pkg::CAP0_OFF, 32'h0, 32'h0);
      c0 = rd_v;
      rd(capcmp_pkg::CAP1_OFF, 32'h0, 32'h0);
      chk_num((rd_v - c0) & 32'hffff, h >> capcmp_pkg::TAP1_LOG);
      rd(capcmp_pkg::FFCR_OFF, 32'h14, 32'h17);
      // Time difference between the two inputs
      wb(1'b1, capcmp_pkg::MODE_OFF, md(capcmp_pkg::CLK_TAP1, capcmp_pkg::CPM_TWO));
      h = 4 * (2 + ($unsigned($random(seed)) % 8));
      src.drive(1'b1, 1'b0, 1'b0, h);
      src.drive(1'b1, 1'b1, 1'b0, 4);
      src.drive(1'b0, 1'b0, 1'b0, 4);
      rd(capcmp_pkg::CAP0_OFF, 32'h0, 32'h0);
      c0 = rd_v;
      rd(capcmp_pkg::CAP1_OFF, 32'h0, 32'h0);
      chk_num((rd_v - c0) & 32'hffff, h >> capcmp_pkg::TAP1_LOG);
      rd(capcmp_pkg::FFCR_OFF, 32'h04, 32'h17);
      // Software capture also toggles the flip-flop
      wb(1'b1, capcmp_pkg::MODE_OFF, md(capcmp_pkg::CLK_TAP1, capcmp_pkg::CPM_TWO)
         | (32'h1 << capcmp_pkg::MODE_SWCAP_BIT));
      rd(capcmp_pkg::FFCR_OFF, 32'h14, 32'h17);
      // Compare matches under three toggle settings
      wb(1'b1, capcmp_pkg::MODE_OFF, md(capcmp_pkg::CLK_TAP1, capcmp_pkg::CPM_OFF));
      wb(1'b1, capcmp_pkg::CMP0_OFF, 32'd10);
      wb(1'b1, capcmp_pkg::CMP1_OFF, 32'd20);
      foreach (ffc[i]) begin
         base = irq_n;
         base0 = cm0_n;
         wb(1'b1, capcmp_pkg::RUN_OFF, 32'h0);
         wb(1'b1, capcmp_pkg::FFCR_OFF, ffc[i]);
         wb(1'b1, capcmp_pkg::RUN_OFF, 32'h3);
         repeat (56) @(posedge clk_i);
         rd(capcmp_pkg::FFCR_OFF, 32'h10, 32'h10);
         repeat (40) @(posedge clk_i);
         rd(capcmp_pkg::FFCR_OFF, {27'h0, ffe[i], 4'h0}, 32'h10);
         chk_num(irq_n - base, 32'd1);
         chk_num(cm0_n - base0, 32'd1);
      end
      test_done();
   end
endmodule : tb
`default_nettype wire
